// >>> hw/cvpc_top.sv
// What this block does
// (RL1) One PCM sample each way every period
// (RL2) Two eight-word CVSD FIFOs, in and out
// (RL3) Double-buffered PCM in and out registers
// (RL4) Core runs from gated 2 MHz divided tick
// (RL5) CVSD word every two PCM samples
// (RL6) Sample interrupt every period when enabled
// (RL7) DMA request every period when enabled
// (RL8) FIFO level interrupt when enabled
// (RL9) Interpolate to 64 kHz, then delta encode
// (RL10) Delta decode, then decimate to 8 kHz
// (RL11) Stream path converts selected format automatically
// (RL12) Standalone converter answers on register write
// (RL13) Standalone converts only log to/from linear
// (RL14) Mu-law uses left-aligned 14-bit linear
// (RL15) A-law uses left-aligned 13-bit linear
// (RL16) Gate off stops core, standalone still works
// (RL17) Format select bits pick stream format
// (RL18) Core works on signed 16-bit samples
// (RL19) Attenuation shifts input right 0-3 bits
// (RL20) Log codes expanded to 16-bit linear first
// (RL21) Gate off keeps contents, no periodic events
// (RL22) Out FIFO nearly full at three free
// (RL23) In FIFO nearly empty at three left
// (RL24) Empty in FIFO yields checkerboard pattern
// (RL25) Full out FIFO discards new words
//
// Local design decisions: the address map and the AXI4-Lite register port.
`timescale 1ns/100ps
module cvpc_top #(
  parameter int AUX_DIV_CYCLES = cvpc_pkg::AUX_DIV
) (
  input logic aclk,
  input logic aresetn,
  input logic awvalid,
  output logic awready,
  input logic [7:0] awaddr,
  input logic wvalid,
  output logic wready,
  input logic [31:0] wdata,
  input logic [3:0] wstrb,
  output logic bvalid,
  input logic bready,
  output logic [1:0] bresp,
  input logic arvalid,
  output logic arready,
  input logic [7:0] araddr,
  output logic rvalid,
  input logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic irq,
  output logic dma_pcm_req
);
  import cvpc_pkg::*;

  typedef struct packed {
    logic aw_ready;
    logic aw_got;
    logic [5:0] aw_idx;
    logic w_ready;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_valid;
    logic [1:0] b_resp;
    logic ar_ready;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    cvpc_ctrl_t ctrl;
    logic [15:0] pcm_in_hold;
    logic pcm_in_full;
    logic [15:0] pcm_out;
    logic pcm_out_full;
    logic [7:0] comp_out;
    logic [15:0] unif_out;
    logic [FIFO_WORDS-1:0][15:0] in_mem;
    logic [2:0] in_wp;
    logic [2:0] in_rp;
    logic [3:0] in_cnt;
    logic [FIFO_WORDS-1:0][15:0] out_mem;
    logic [2:0] out_wp;
    logic [2:0] out_rp;
    logic [3:0] out_cnt;
    logic [15:0] aux_cnt;
    logic [8:0] phase;
    logic [2:0] sub;
    logic signed [15:0] prev;
    logic signed [15:0] cur;
    cvpc_cvsd_t enc;
    cvpc_cvsd_t dec;
    logic [15:0] enc_word;
    logic [3:0] enc_bits;
    logic [15:0] dec_word;
    logic [3:0] dec_bits;
    logic signed [18:0] dec_sum;
    logic sample_flag;
    logic irq;
    logic dma_req;
  } cvpc_state_t;

  cvpc_state_t st_reg;
  cvpc_state_t st_next;
  cvpc_stat_t stat;
  logic do_write;
  logic aux_tick;
  logic bit_tick;
  logic ebit;
  logic dbit;
  logic [31:0] wmerge;
  logic [15:0] lin;
  int interp;

  // ----------------------------------------
  // Companding, CVSD and byte-lane merge helpers
  // ----------------------------------------
  function automatic logic [7:0] mu_compress(logic [15:0] x);
    int v;
    int seg;
    int k;
    logic [7:0] mask;
    logic [7:0] u;
    v = int'($signed(x)) >>> 2; // RL14
    mask = MU_MASK_POS;
    if (v < 0)
    begin
      v = -v;
      mask = MU_MASK_NEG;
    end
    if (v > MU_CLIP)
      v = MU_CLIP;
    v = v + MU_BIAS;
    seg = 8;
    for (k = 7; k >= 0; k--)
      if (v < (MU_SEG0 << k))
        seg = k;
    if (seg > 7)
      u = SEG_OVER;
    else
      u = {1'b0, seg[2:0], 4'(v >> (seg + 1))};
    return u ^ mask;
  endfunction : mu_compress

  function automatic logic [15:0] mu_expand(logic [7:0] c);
    logic [7:0] u;
    int t;
    u = ~c;
    t = (int'(u[3:0]) << 3) + MU_EXP_BIAS;
    t = t << u[6:4];
    t = u[7] ? MU_EXP_BIAS - t : t - MU_EXP_BIAS; // RL14
    return 16'(t);
  endfunction : mu_expand

  function automatic logic [7:0] a_compress(logic [15:0] x);
    int v;
    int seg;
    int k;
    logic [7:0] mask;
    logic [7:0] a;
    v = int'($signed(x)) >>> 3; // RL15
    mask = A_MASK_POS;
    if (v < 0)
    begin
      v = -v - 1;
      mask = A_MASK_NEG;
    end
    seg = 8;
    for (k = 7; k >= 0; k--)
      if (v < (A_SEG0 << k))
        seg = k;
    if (seg > 7)
      a = SEG_OVER;
    else if (seg < 2)
      a = {1'b0, seg[2:0], 4'(v >> 1)};
    else
      a = {1'b0, seg[2:0], 4'(v >> seg)};
    return a ^ mask;
  endfunction : a_compress

  function automatic logic [15:0] a_expand(logic [7:0] c);
    logic [7:0] a;
    int t;
    a = c ^ A_MASK_NEG;
    t = int'(a[3:0]) << 4;
    if (a[6:4] == 3'h0)
      t = t + A_OFS0;
    else if (a[6:4] == 3'h1)
      t = t + A_OFS1;
    else
      t = (t + A_OFS1) << (a[6:4] - 3'h1);
    return a[7] ? 16'(t) : 16'(-t); // RL15
  endfunction : a_expand

  // Linear formats pass through; log codes sit in the low byte
  function automatic logic [15:0] to_linear(cvpc_format_t f, logic [15:0] x);
    case (f)
      FMT_ULAW: return mu_expand(x[7:0]); // RL20
      FMT_ALAW: return a_expand(x[7:0]); // RL20
      default: return x;
    endcase
  endfunction : to_linear

  function automatic logic [15:0] from_linear(cvpc_format_t f, logic [15:0] x);
    case (f)
      FMT_ULAW: return {8'h00, mu_compress(x)};
      FMT_ALAW: return {8'h00, a_compress(x)};
      default: return x;
    endcase
  endfunction : from_linear

  // Shared by encoder and decoder so both track the same estimate
  function automatic cvpc_cvsd_t cvsd_step(cvpc_cvsd_t s, logic b);
    cvpc_cvsd_t n;
    int st;
    int acc;
    n.hist = {s.hist[2:0], b};
    st = int'(s.step);
    if (n.hist == 4'hf || n.hist == 4'h0)
      st = (st + STEP_MIN > STEP_MAX) ? STEP_MAX : st + STEP_MIN;
    else
      st = st - (st >>> STEP_DECAY_SHIFT);
    if (st < STEP_MIN)
      st = STEP_MIN;
    acc = int'(s.acc); // RL18
    acc = acc - (acc >>> ACC_DECAY_SHIFT);
    acc = b ? acc + st : acc - st;
    if (acc > ACC_MAX)
      acc = ACC_MAX;
    if (acc < ACC_MIN)
      acc = ACC_MIN;
    n.acc = 16'(acc);
    n.step = 11'(st);
    return n;
  endfunction : cvsd_step

  function automatic logic [31:0] lane_merge(logic [31:0] o, logic [31:0] n, logic [3:0] strb);
    logic [31:0] m;
    int i;
    m = o;
    for (i = 0; i < 4; i++)
      if (strb[i])
        m[i*8 +: 8] = n[i*8 +: 8];
    return m;
  endfunction : lane_merge

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_next = st_reg;
    st_next.dma_req = 1'b0;
    wmerge = 32'h0;
    lin = 16'h0;
    interp = 0;
    ebit = 1'b0;
    dbit = 1'b0;
    stat = '0;
    // Bus write channels, address and data in either order
    if (st_reg.aw_ready && awvalid)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_idx = awaddr[7:2];
    end
    if (st_reg.w_ready && wvalid)
    begin
      st_next.w_got = 1'b1;
      st_next.w_data = wdata;
      st_next.w_strb = wstrb;
    end
    if (st_reg.b_valid && bready)
      st_next.b_valid = 1'b0;
    do_write = st_next.aw_got && st_next.w_got && !st_next.b_valid;
    if (do_write)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.b_valid = 1'b1;
      st_next.b_resp = RESP_OKAY;
      case (st_next.aw_idx)
        IDX_STREAM_IN:
        begin
          wmerge = lane_merge(32'h0, st_next.w_data, st_next.w_strb);
          if (st_next.in_cnt != FIFO_FULL) // RL2
          begin
            st_next.in_mem[st_next.in_wp] = wmerge[15:0];
            st_next.in_wp = st_next.in_wp + 3'h1;
            st_next.in_cnt = st_next.in_cnt + 4'h1;
          end
        end
        IDX_PCM_IN:
        begin
          wmerge = lane_merge({16'h0, st_reg.pcm_in_hold}, st_next.w_data, st_next.w_strb);
          st_next.pcm_in_hold = wmerge[15:0]; // RL3
          st_next.pcm_in_full = 1'b1;
        end
        IDX_COMPANDED_IN:
        begin
          if (!st_reg.ctrl.standalone_format_direction) // RL12
            st_next.unif_out = st_reg.ctrl.standalone_law ? a_expand(st_next.w_data[7:0])
              : mu_expand(st_next.w_data[7:0]); // RL13
        end
        IDX_UNIFORM_IN:
        begin
          if (st_reg.ctrl.standalone_format_direction) // RL12
            st_next.comp_out = st_reg.ctrl.standalone_law ? a_compress(st_next.w_data[15:0])
              : mu_compress(st_next.w_data[15:0]); // RL13
        end
        IDX_CONTROL:
        begin
          wmerge = lane_merge({22'h0, st_reg.ctrl}, st_next.w_data, st_next.w_strb);
          st_next.ctrl = cvpc_ctrl_t'(wmerge[9:0]);
        end
        IDX_STREAM_OUT, IDX_PCM_OUT, IDX_COMPANDED_OUT, IDX_UNIFORM_OUT, IDX_STATUS:
          st_next.b_resp = RESP_OKAY;
        default:
          st_next.b_resp = RESP_SLVERR;
      endcase
    end
    // Bus read channel; reads with side effects act once, at acceptance
    if (st_reg.r_valid && rready)
      st_next.r_valid = 1'b0;
    if (st_reg.ar_ready && arvalid)
    begin
      st_next.r_valid = 1'b1;
      st_next.r_resp = RESP_OKAY;
      st_next.r_data = 32'h0;
      case (araddr[7:2])
        IDX_STREAM_OUT:
        begin
          // Empty read returns zero and leaves the pointers alone
          if (st_next.out_cnt != 4'h0)
          begin
            st_next.r_data = {16'h0, st_next.out_mem[st_next.out_rp]};
            st_next.out_rp = st_next.out_rp + 3'h1;
            st_next.out_cnt = st_next.out_cnt - 4'h1;
          end
        end
        IDX_PCM_OUT:
        begin
          st_next.r_data = {16'h0, st_reg.pcm_out}; // RL3
          st_next.pcm_out_full = 1'b0;
        end
        IDX_COMPANDED_OUT:
          st_next.r_data = {24'h0, st_reg.comp_out};
        IDX_UNIFORM_OUT:
          st_next.r_data = {16'h0, st_reg.unif_out};
        IDX_CONTROL:
          st_next.r_data = {22'h0, st_reg.ctrl};
        IDX_STATUS:
        begin
          st_next.r_data = {17'h0, stat_of(st_reg)};
          st_next.sample_flag = 1'b0;
        end
        IDX_STREAM_IN, IDX_PCM_IN, IDX_COMPANDED_IN, IDX_UNIFORM_IN:
          st_next.r_data = 32'h0;
        default:
          st_next.r_resp = RESP_SLVERR;
      endcase
    end
    // ----------------------------------------
    // Converter core, paced by the divided auxiliary tick
    // ----------------------------------------
    // Gate off freezes the counters so the period resumes where it stopped
    aux_tick = st_reg.ctrl.core_clock_gate && (st_reg.aux_cnt == 16'(AUX_DIV_CYCLES - 1)); // RL4 RL16
    if (st_reg.ctrl.core_clock_gate)
      st_next.aux_cnt = aux_tick ? 16'h0 : st_reg.aux_cnt + 16'h1; // RL4
    bit_tick = aux_tick && (st_reg.phase + PHASE_STEP >= PHASE_WRAP);
    if (aux_tick)
      st_next.phase = bit_tick ? st_reg.phase + PHASE_STEP - PHASE_WRAP : st_reg.phase + PHASE_STEP;
    if (bit_tick) // RL21
    begin
      if (st_reg.sub == 3'h0)
      begin
        st_next.pcm_out = from_linear(st_reg.ctrl.stream_format_select, 16'(st_reg.dec_sum >>> 3)); // RL10 RL11
        st_next.pcm_out_full = 1'b1; // RL1 RL3
        st_next.dec_sum = 19'sh0;
        lin = to_linear(st_reg.ctrl.stream_format_select, st_reg.pcm_in_hold); // RL11 RL17
        st_next.prev = st_reg.cur;
        st_next.cur = $signed(lin) >>> st_reg.ctrl.attenuation; // RL19
        // A write landing on the same edge keeps the flag set for the new sample
        if (!(do_write && st_next.aw_idx == IDX_PCM_IN))
          st_next.pcm_in_full = 1'b0; // RL1
        st_next.sample_flag = 1'b1; // RL6
        st_next.dma_req = st_reg.ctrl.dma_enable; // RL7
      end
      interp = int'(st_next.prev) + ((int'(st_next.cur) - int'(st_next.prev)) * int'(st_reg.sub) >>> 3); // RL9
      ebit = ($signed(16'(interp)) >= st_reg.enc.acc); // RL9
      st_next.enc = cvsd_step(st_reg.enc, ebit);
      st_next.enc_word = {ebit, st_reg.enc_word[15:1]};
      st_next.enc_bits = st_reg.enc_bits + 4'h1;
      if (st_reg.enc_bits == 4'hf && st_next.out_cnt != FIFO_FULL) // RL5 RL25
      begin
        st_next.out_mem[st_next.out_wp] = st_next.enc_word;
        st_next.out_wp = st_next.out_wp + 3'h1;
        st_next.out_cnt = st_next.out_cnt + 4'h1;
      end
      st_next.dec_word = st_reg.dec_word;
      if (st_reg.dec_bits == 4'h0)
      begin
        st_next.dec_word = CHECKER; // RL24
        if (st_next.in_cnt != 4'h0) // RL2
        begin
          st_next.dec_word = st_next.in_mem[st_next.in_rp];
          st_next.in_rp = st_next.in_rp + 3'h1;
          st_next.in_cnt = st_next.in_cnt - 4'h1;
        end
      end
      dbit = st_next.dec_word[0];
      st_next.dec_word = {1'b0, st_next.dec_word[15:1]};
      st_next.dec_bits = st_reg.dec_bits + 4'h1;
      st_next.dec = cvsd_step(st_reg.dec, dbit); // RL10
      st_next.dec_sum = st_next.dec_sum + 19'(st_next.dec.acc); // RL10
      st_next.sub = st_reg.sub + 3'h1;
    end
    // ----------------------------------------
    // Handshake readiness and interrupt line
    // ----------------------------------------
    st_next.aw_ready = !st_next.aw_got && !st_next.b_valid;
    st_next.w_ready = !st_next.w_got && !st_next.b_valid;
    st_next.ar_ready = !st_next.r_valid;
    stat = stat_of(st_next);
    st_next.irq = (st_next.sample_flag && st_next.ctrl.sample_irq_enable) // RL6
      || ((stat.out_fifo_nearly_full || stat.in_fifo_nearly_empty)
      && st_next.ctrl.fifo_level_irq_enable); // RL8 RL22 RL23
  end

  function automatic cvpc_stat_t stat_of(cvpc_state_t s);
    cvpc_stat_t t;
    t.pcm_out_full = s.pcm_out_full;
    t.pcm_in_full = s.pcm_in_full;
    t.sample_flag = s.sample_flag;
    t.in_empty = (s.in_cnt == 4'h0);
    t.out_full = (s.out_cnt == FIFO_FULL);
    t.in_fifo_nearly_empty = (s.in_cnt <= NEAR_LEVEL); // RL23
    t.out_fifo_nearly_full = (s.out_cnt >= OUT_NEAR_FILL); // RL22
    t.in_count = s.in_cnt;
    t.out_count = s.out_cnt;
    return t;
  endfunction : stat_of

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign awready = st_reg.aw_ready;
  assign wready = st_reg.w_ready;
  assign bvalid = st_reg.b_valid;
  assign bresp = st_reg.b_resp;
  assign arready = st_reg.ar_ready;
  assign rvalid = st_reg.r_valid;
  assign rdata = st_reg.r_data;
  assign rresp = st_reg.r_resp;
  assign irq = st_reg.irq;
  assign dma_pcm_req = st_reg.dma_req;
endmodule : cvpc_top

// >>> inc/cvpc_pkg.sv
package cvpc_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int AUX_PERIOD_NS = 500;
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int AUX_DIV = AUX_PERIOD_NS / CLK_PERIOD_NS;
  localparam int AUX_PER_SAMPLE = SAMPLE_PERIOD_NS / AUX_PERIOD_NS;
  localparam int BITS_PER_SAMPLE = 8;
  localparam logic [8:0] PHASE_STEP = 9'(BITS_PER_SAMPLE);
  localparam logic [8:0] PHASE_WRAP = 9'(AUX_PER_SAMPLE);
  // ----------------------------------------
  // Register word indices, byte address is four times the index
  // ----------------------------------------
  localparam logic [5:0] IDX_STREAM_IN = 6'h20;
  localparam logic [5:0] IDX_STREAM_OUT = 6'h22;
  localparam logic [5:0] IDX_PCM_IN = 6'h24;
  localparam logic [5:0] IDX_PCM_OUT = 6'h26;
  localparam logic [5:0] IDX_COMPANDED_IN = 6'h28;
  localparam logic [5:0] IDX_COMPANDED_OUT = 6'h2a;
  localparam logic [5:0] IDX_UNIFORM_IN = 6'h2c;
  localparam logic [5:0] IDX_UNIFORM_OUT = 6'h2e;
  localparam logic [5:0] IDX_CONTROL = 6'h30;
  localparam logic [5:0] IDX_STATUS = 6'h32;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ----------------------------------------
  // FIFOs and codec constants
  // ----------------------------------------
  localparam int FIFO_WORDS = 8;
  localparam logic [3:0] FIFO_FULL = 4'h8;
  localparam logic [3:0] NEAR_LEVEL = 4'h3;
  localparam logic [3:0] OUT_NEAR_FILL = 4'h5;
  localparam logic [15:0] CHECKER = 16'haaaa;
  localparam int STEP_MIN = 10;
  localparam int STEP_MAX = 1280;
  localparam int ACC_DECAY_SHIFT = 5;
  localparam int STEP_DECAY_SHIFT = 10;
  localparam int ACC_MAX = 32767;
  localparam int ACC_MIN = -32768;
  localparam int MU_CLIP = 8159;
  localparam int MU_BIAS = 33;
  localparam int MU_EXP_BIAS = 132;
  localparam int MU_SEG0 = 64;
  localparam int A_SEG0 = 32;
  localparam int A_OFS0 = 8;
  localparam int A_OFS1 = 264;
  localparam logic [7:0] MU_MASK_POS = 8'hff;
  localparam logic [7:0] MU_MASK_NEG = 8'h7f;
  localparam logic [7:0] A_MASK_POS = 8'hd5;
  localparam logic [7:0] A_MASK_NEG = 8'h55;
  localparam logic [7:0] SEG_OVER = 8'h7f;
  typedef enum logic [1:0] {FMT_LINEAR = 2'h0, FMT_ULAW = 2'h1, FMT_ALAW = 2'h2, FMT_LINEAR_ALT = 2'h3} cvpc_format_t;
  typedef struct packed {
    logic dma_enable;
    logic [1:0] attenuation;
    logic standalone_law;
    logic standalone_format_direction;
    cvpc_format_t stream_format_select;
    logic fifo_level_irq_enable;
    logic sample_irq_enable;
    logic core_clock_gate;
  } cvpc_ctrl_t;
  typedef struct packed {
    logic pcm_out_full;
    logic pcm_in_full;
    logic sample_flag;
    logic in_empty;
    logic out_full;
    logic in_fifo_nearly_empty;
    logic out_fifo_nearly_full;
    logic [3:0] in_count;
    logic [3:0] out_count;
  } cvpc_stat_t;
  typedef struct packed {
    logic signed [15:0] acc;
    logic [10:0] step;
    logic [3:0] hist;
  } cvpc_cvsd_t;
endpackage : cvpc_pkg

// >>> tb/cvpc_properties.sv
`timescale 1ns/100ps
module cvpc_properties #(
  parameter int AUX_DIV_CYCLES = 100
) (
  input logic aclk,
  input logic aresetn,
  input logic awvalid,
  input logic awready,
  input logic wvalid,
  input logic wready,
  input logic bvalid,
  input logic bready,
  input logic [1:0] bresp,
  input logic arvalid,
  input logic arready,
  input logic rvalid,
  input logic rready,
  input logic [31:0] rdata,
  input logic [1:0] rresp,
  input logic dma_pcm_req
);
  // ----
  // Sample spacing counter
  // ----
  localparam int PER = 250 * AUX_DIV_CYCLES;
  int gap_reg;
  logic seen_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      gap_reg <= 0;
      seen_reg <= 1'b0;
    end
    else if (dma_pcm_req)
    begin
      gap_reg <= 1;
      seen_reg <= 1'b1;
    end
    else
      gap_reg <= gap_reg + 1;
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_take;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd_take;
    arvalid && arready;
  endsequence
  AST_B_LAT: assert property (s_wr_take |=> bvalid) else $error("write answer late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped");
  AST_B_REFUSE: assert property (bvalid |-> !awready && !wready) else $error("write taken early");
  AST_B_DONE: assert property (bvalid && bready |=> !bvalid) else $error("bvalid stuck");
  AST_R_LAT: assert property (s_rd_take |=> rvalid && !arready) else $error("read answer late");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("rdata dropped");
  AST_R_DONE: assert property (rvalid && rready |=> !rvalid && arready) else $error("read not closed");
  AST_DMA_PULSE: assert property ($rose(dma_pcm_req) |=> !dma_pcm_req) else $error("dma pulse long");
  AST_DMA_GAP: assert property (dma_pcm_req && seen_reg |-> gap_reg >= PER) else $error("dma too soon");
endmodule : cvpc_properties
bind cvpc_top cvpc_properties #(.AUX_DIV_CYCLES(AUX_DIV_CYCLES)) chk_u (.aclk(aclk), .aresetn(aresetn),
  .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
  .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .rresp(rresp), .dma_pcm_req(dma_pcm_req));

// >>> tb/cvpc_dma_model.sv
`timescale 1ns/100ps
module cvpc_dma_model (
  input logic aclk,
  input logic aresetn,
  input logic dma_pcm_req,
  output int pulse_cnt,
  output int gap_cnt
);
  // Counts requests and the spacing between the last two
  int cyc_reg;
  int last_reg;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pulse_cnt <= 0;
      gap_cnt <= 0;
      cyc_reg <= 0;
      last_reg <= 0;
    end
    else
    begin
      cyc_reg <= cyc_reg + 1;
      if (dma_pcm_req)
      begin
        pulse_cnt <= pulse_cnt + 1;
        gap_cnt <= cyc_reg - last_reg;
        last_reg <= cyc_reg;
      end
    end
  end
endmodule : cvpc_dma_model

// >>> tb/tb.sv
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin bad_count++; \
  $display("Error %s expected %h seen %h", n, e, g); end end
module tb;
  import cvpc_pkg::*;
  localparam int DIV = 2;
  localparam int PER = 250 * DIV;
  localparam logic [7:0] A_SIN = {IDX_STREAM_IN, 2'h0};
  localparam logic [7:0] A_SOUT = {IDX_STREAM_OUT, 2'h0};
  localparam logic [7:0] A_POUT = {IDX_PCM_OUT, 2'h0};
  localparam logic [7:0] A_CIN = {IDX_COMPANDED_IN, 2'h0};
  localparam logic [7:0] A_COUT = {IDX_COMPANDED_OUT, 2'h0};
  localparam logic [7:0] A_UIN = {IDX_UNIFORM_IN, 2'h0};
  localparam logic [7:0] A_UOUT = {IDX_UNIFORM_OUT, 2'h0};
  localparam logic [7:0] A_CTL = {IDX_CONTROL, 2'h0};
  localparam logic [7:0] A_ST = {IDX_STATUS, 2'h0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, irq, dma_pcm_req;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d, d0;
  logic [7:0] codes [8] = '{8'h80, 8'h00, 8'h9f, 8'h35, 8'hd5, 8'h55, 8'haa, 8'h2a};
  int bad_count = 0;
  int n_compared = 0;
  int pulses, gap, i, k;
  always #2.5 aclk = ~aclk;
  cvpc_top #(.AUX_DIV_CYCLES(DIV)) dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
    .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .irq(irq),
    .dma_pcm_req(dma_pcm_req));
  cvpc_dma_model dma_u (.aclk(aclk), .aresetn(aresetn), .dma_pcm_req(dma_pcm_req), .pulse_cnt(pulses),
    .gap_cnt(gap));
  // ----
  // Bus tasks; every handshake is judged on the values standing at the rising edge
  // ----
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    rs = 2'h0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (awvalid && awready)
        awvalid <= 1'b0;
      if (wvalid && wready)
        wvalid <= 1'b0;
      if (bvalid && bready)
      begin
        done = 1'b1;
        rs = bresp;
        bready <= 1'b0;
      end
    end
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic done;
    done = 1'b0;
    v = 32'h0;
    rs = 2'h0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done)
    begin
      @(posedge aclk);
      if (arvalid && arready)
        arvalid <= 1'b0;
      if (rvalid && rready)
      begin
        done = 1'b1;
        v = rdata;
        rs = rresp;
        rready <= 1'b0;
      end
    end
  endtask : rd
  // No local limit: the watchdog ends a wait that never finishes
  task automatic wait_pulse(input int n);
    while (pulses < n)
      @(posedge aclk);
  endtask : wait_pulse
  function automatic logic [15:0] expand(input logic alaw, input logic [7:0] c);
    logic [7:0] u;
    int t;
    u = alaw ? c ^ 8'h55 : ~c;
    if (!alaw)
    begin
      t = ((u[3:0] << 3) + 132) << u[6:4];
      return u[7] ? 16'(132 - t) : 16'(t - 132);
    end
    t = (u[3:0] << 4) + ((u[6:4] == 3'h0) ? 8 : 264);
    if (u[6:4] > 3'h1) t = t << (u[6:4] - 1);
    return u[7] ? 16'(t) : 16'(-t);
  endfunction : expand
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict
  // Sized for the full run, about 12000 cycles of work
  initial
  begin
    repeat (60000) @(posedge aclk);
    bad_count++;
    print_verdict();
  end
  // ----
  // Tests
  // ----
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_CTL, d, r);
    `CHK("control", 32'h0, d)
    rd(A_ST, d, r);
    `CHK("status", 32'h00000a00, d)
    rd(8'h00, d, r);
    `CHK("rresp", RESP_SLVERR, r)
    wr(8'hfc, 32'h1, r);
    `CHK("bresp", RESP_SLVERR, r)
    for (i = 0; i < 4; i++)
    begin
      wr(A_CTL, 32'(i << 3 | i << 7), r);
      rd(A_CTL, d, r);
      `CHK("control", 32'(i << 3 | i << 7), d)
    end
    // Gate stays off here, so the standalone path must work without the core
    for (i = 0; i < 8; i++)
    begin
      k = i / 4;
      wr(A_CTL, 32'(k << 6), r);
      wr(A_CIN, 32'(codes[i]), r);
      rd(A_UOUT, d, r);
      `CHK("uniform", 32'(expand(k[0], codes[i])), d)
      wr(A_CTL, 32'(k << 6 | 32), r);
      wr(A_UIN, 32'(expand(k[0], codes[i]) | (k ? 16'h7 : 16'h3)), r);
      rd(A_COUT, d, r);
      `CHK("companded", 32'(codes[i]), d)
    end
    wr(A_CTL, 32'h4, r);
    repeat (2) @(negedge aclk);
    `CHK("irq", 1'b1, irq)
    for (i = 1; i <= 9; i++)
    begin
      wr(A_SIN, 32'(i), r);
      rd(A_ST, d, r);
      `CHK("in count", 4'(i > 8 ? 8 : i), d[7:4])
      `CHK("in nearly empty", i <= 3, d[9])
    end
    @(negedge aclk);
    `CHK("irq", 1'b0, irq)
    wr(A_CTL, 32'h203, r);
    wait_pulse(3);
    `CHK("dma gap", PER, gap)
    repeat (2) @(negedge aclk);
    `CHK("irq", 1'b1, irq)
    rd(A_ST, d, r);
    `CHK("sample flag", 1'b1, d[12])
    `CHK("pcm out full", 1'b1, d[14])
    @(negedge aclk);
    `CHK("irq", 1'b0, irq)
    rd(A_POUT, d, r);
    rd(A_ST, d, r);
    `CHK("pcm out full", 1'b0, d[14])
    wait_pulse(pulses + 1);
    rd(A_ST, d0, r);
    wait_pulse(pulses + 4);
    rd(A_ST, d, r);
    `CHK("in taken", d0[7:4] - 4'h2, d[7:4])
    `CHK("out added", d0[3:0] + 4'h2, d[3:0])
    k = 0;
    i = 0;
    while (k < 4 && i < 40)
    begin
      wait_pulse(pulses + 1);
      rd(A_ST, d, r);
      `CHK("out nearly full", d[3:0] >= 4'h5, d[8])
      `CHK("out full", d[3:0] == 4'h8, d[10])
      if (d[3:0] == 4'h8) k++;
      i++;
    end
    `CHK("out held", 4'h8, d[3:0])
    wr(A_CTL, 32'h0, r);
    k = pulses;
    repeat (3 * PER) @(posedge aclk);
    `CHK("no dma", k, pulses)
    rd(A_ST, d, r);
    `CHK("out kept", 4'h8, d[3:0])
    for (i = 0; i < 9; i++)
      rd(A_SOUT, d, r);
    `CHK("empty pop", 32'h0, d)
    rd(A_ST, d, r);
    `CHK("out drained", 4'h0, d[3:0])
    wr({IDX_PCM_IN, 2'h0}, 32'h1234, r);
    rd(A_ST, d, r);
    `CHK("pcm in full", 1'b1, d[13])
    print_verdict();
  end
endmodule : tb
